// >>> inc/ssreg_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SSREG_REGS_SVH
`define SSREG_REGS_SVH
`define SSREG_UPSTREAM_SLOT_FIELD_ADDR 8'h0e
`define SSREG_RESPCYC_ADDR 8'h0f
`define SSREG_SLOTFMT_ADDR 8'h10
`define SSREG_UPSLOT_MSB 5
`define SSREG_UPSLOT_MAX 6'h20
`define SSREG_UPSTREAM_FORMAT_SELECT_BIT 7
`define SSREG_UPSTREAM_SLOT_WIDTH_MSB 6
`define SSREG_UPSTREAM_SLOT_WIDTH_LSB 4
`define SSREG_UPSTREAM_SLOT_FIELD_RST 8'h00
`define SSREG_RESPCYC_RST 8'h40
`define SSREG_SLOTFMT_RST 8'h00
`define SSREG_SUPERFRAME_BITS 11'h400
`define SSREG_RESP_SCALE 4
`endif

// >>> inc/ssreg_pkg.sv
// types shared by the slot structure register bank
`default_nettype none
package ssreg_pkg;
  // source of a register access
  typedef enum logic [1:0] {
    SSREG_SRC_LOCAL = 2'h1,
    SSREG_SRC_BUS = 2'h2
  } ssreg_src_t;
  // upstream slot encoding chosen by format and width
  typedef enum logic [2:0] {
    SSREG_ENC_PARITY = 3'h1,
    SSREG_ENC_FLOAT = 3'h2,
    SSREG_ENC_ECC = 3'h4
  } ssreg_enc_t;
  // broadcast sequencer states
  typedef enum logic [1:0] {
    SSREG_BC_IDLE = 2'h1,
    SSREG_BC_SEND = 2'h2
  } ssreg_bc_state_t;
endpackage : ssreg_pkg
`default_nettype wire

// >>> design/ssreg_fmt_decode.sv
// upstream slot format decoder: encoding and protection bit count
`timescale 1ns/10ps
`default_nettype none
`include "ssreg_regs.svh"
module ssreg_fmt_decode
  import ssreg_pkg::*;
(
  input wire logic [7:0] fmt,
  output ssreg_enc_t enc,
  output logic [2:0] ecc_bits
);
  // width code: 0=8,1=12,2=16,3=20,4=24,5=28,6=32
  wire [2:0] size_code = fmt[`SSREG_UPSTREAM_SLOT_WIDTH_MSB:`SSREG_UPSTREAM_SLOT_WIDTH_LSB];
  wire alt = fmt[`SSREG_UPSTREAM_FORMAT_SELECT_BIT];
  wire is_float_w = (size_code == 3'h1) || (size_code == 3'h2) ||
                    (size_code == 3'h3);
  wire is_ecc_w = (size_code == 3'h4) || (size_code == 3'h6);
  // 8- and 28-bit widths ignore the alternate bit
  assign enc = (alt && is_float_w) ? SSREG_ENC_FLOAT :
               (alt && is_ecc_w) ? SSREG_ENC_ECC : SSREG_ENC_PARITY;
  // six check bits at 24, seven at 32
  assign ecc_bits = (enc != SSREG_ENC_ECC) ? 3'h0 :
                    (size_code == 3'h4) ? 3'h6 : 3'h7;
endmodule : ssreg_fmt_decode
`default_nettype wire

// >>> design/ssreg_bank.sv
// slot structure register bank with staged and committed copies
`timescale 1ns/10ps
`default_nettype none
`include "ssreg_regs.svh"
module ssreg_bank
  import ssreg_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic is_main,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire ssreg_src_t wr_src,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rd_valid,
  input wire logic commit,
  input wire logic discovery,
  input wire logic bc_ready,
  output logic bc_valid,
  output logic [7:0] bc_data,
  output logic [7:0] disc_timing,
  output logic [5:0] up_slots_act,
  output logic [7:0] resp_cyc_act,
  output logic [7:0] slot_fmt_act,
  output logic [9:0] up_hdr_bit,
  output ssreg_enc_t up_enc,
  output logic [2:0] up_ecc_bits,
  output logic sf_start
);
  // elaboration check: offsets must fit the address
  if (ADDR_W < 5)
  begin : g_addr_chk
    $error("ssreg_bank: ADDR_W too small for register map");
  end

  // address match, shared by read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  // staged copies written by software
  logic [7:0] up_stage_reg;
  logic [7:0] resp_stage_reg;
  logic [7:0] fmt_stage_reg;
  // committed copies steering the bus timing
  logic [7:0] up_act_reg;
  logic [7:0] resp_act_reg;
  logic [7:0] fmt_act_reg;
  logic [7:0] disc_reg;
  logic [7:0] rdata_reg;
  logic rd_valid_reg;
  logic [7:0] bc_data_reg;
  ssreg_bc_state_t bc_state_reg;
  ssreg_bc_state_t bc_state_next;
  logic [9:0] bit_cnt_reg;

  // write decode
  wire wr_up = wr_en && hit(addr, `SSREG_UPSTREAM_SLOT_FIELD_ADDR);
  // local port cannot touch the response value
  wire wr_resp = wr_en && hit(addr, `SSREG_RESPCYC_ADDR) &&
                 (wr_src == SSREG_SRC_BUS);
  // format writable locally only in main; over the bus anywhere
  wire wr_fmt = wr_en && hit(addr, `SSREG_SLOTFMT_ADDR) &&
                (is_main || wr_src == SSREG_SRC_BUS);
  // upstream field is six bits; upper bits read zero
  wire [7:0] up_wval = {2'b00, wdata[`SSREG_UPSLOT_MSB:0]};
  // main node local format write kicks off a broadcast
  wire fmt_bcast = wr_fmt && is_main && (wr_src == SSREG_SRC_LOCAL);

  // read decode: reads show the staged values
  wire [7:0] rd_mux = hit(addr, `SSREG_UPSTREAM_SLOT_FIELD_ADDR) ? up_stage_reg :
                      hit(addr, `SSREG_RESPCYC_ADDR) ? resp_stage_reg :
                      hit(addr, `SSREG_SLOTFMT_ADDR) ? fmt_stage_reg :
                      8'h00;

  // staged register writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      up_stage_reg <= `SSREG_UPSTREAM_SLOT_FIELD_RST;
      resp_stage_reg <= `SSREG_RESPCYC_RST;
      fmt_stage_reg <= `SSREG_SLOTFMT_RST;
    end
    else
    begin
      // count above 32 is the writer's fault, stored as given
      if (wr_up)
        up_stage_reg <= up_wval;
      if (wr_resp)
        resp_stage_reg <= wdata;
      if (wr_fmt)
        fmt_stage_reg <= wdata;
    end
  end

  // commit copies staged values; a write in the same cycle
  // lands in the stage and waits for the next commit
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      up_act_reg <= `SSREG_UPSTREAM_SLOT_FIELD_RST;
      resp_act_reg <= `SSREG_RESPCYC_RST;
      fmt_act_reg <= `SSREG_SLOTFMT_RST;
    end
    else if (commit)
    begin
      up_act_reg <= up_stage_reg;
      resp_act_reg <= resp_stage_reg;
      fmt_act_reg <= fmt_stage_reg;
    end
  end

  // discovery timing follows the staged response value
  always_ff @(posedge mclk)
  begin
    if (rst)
      disc_reg <= `SSREG_RESPCYC_RST;
    else if (discovery && is_main)
      disc_reg <= resp_stage_reg;
  end

  // read data, registered one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= rd_en;
      if (rd_en)
        rdata_reg <= rd_mux;
    end
  end

  // broadcast sequencer: one word at a time, held until taken or replaced by a newer write
  always_comb
  begin
    bc_state_next = bc_state_reg;
    unique case (bc_state_reg)
      SSREG_BC_IDLE:
        if (fmt_bcast)
          bc_state_next = SSREG_BC_SEND;
      SSREG_BC_SEND:
        // a new write while waiting just refreshes the data
        if (bc_ready && !fmt_bcast)
          bc_state_next = SSREG_BC_IDLE;
      default:
        bc_state_next = SSREG_BC_IDLE;
    endcase
  end

  // broadcast state and the value being sent
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bc_state_reg <= SSREG_BC_IDLE;
      bc_data_reg <= 8'h00;
    end
    else
    begin
      bc_state_reg <= bc_state_next;
      if (fmt_bcast)
        bc_data_reg <= wdata;
    end
  end

  // bit time counter over one superframe, wraps at 1024
  always_ff @(posedge mclk)
  begin
    if (rst)
      bit_cnt_reg <= 10'h000;
    else
      bit_cnt_reg <= bit_cnt_reg + 10'h001;
  end

  // cycles since the last start, kept apart from the bit counter
  // so the period check does not just restate it
  logic [10:0] sf_gap_reg;
  always_ff @(posedge mclk)
  begin
    if (rst)
      sf_gap_reg <= `SSREG_SUPERFRAME_BITS;
    else if (sf_start)
      sf_gap_reg <= 11'h001;
    else if (sf_gap_reg != 11'h7ff)
      sf_gap_reg <= sf_gap_reg + 11'h001;
  end

  // header offset in bit times is four times the value
  wire [9:0] hdr_bits = {resp_act_reg, 2'b00};

  // slot encoding from the committed format, same in every node
  ssreg_fmt_decode u_fmt_decode (
    .fmt(fmt_act_reg),
    .enc(up_enc),
    .ecc_bits(up_ecc_bits)
  );

  // outputs
  assign rdata = rdata_reg;
  assign rd_valid = rd_valid_reg;
  assign bc_valid = (bc_state_reg == SSREG_BC_SEND);
  assign bc_data = bc_data_reg;
  assign disc_timing = disc_reg;
  // main: total expected; subordinate: pass-through before insert
  assign up_slots_act = up_act_reg[`SSREG_UPSLOT_MSB:0];
  assign resp_cyc_act = resp_act_reg;
  assign slot_fmt_act = fmt_act_reg;
  assign up_hdr_bit = hdr_bits;
  assign sf_start = (bit_cnt_reg == 10'h000);

  // checks
  resp_local_a: assert property (@(posedge mclk)
    disable iff (rst) (wr_en && wr_src == SSREG_SRC_LOCAL &&
     hit(addr, `SSREG_RESPCYC_ADDR)) |=> $stable(resp_stage_reg))
    else $error("local write changed response value");

  sub_fmt_a: assert property (@(posedge mclk)
    disable iff (rst) (!is_main && wr_en && wr_src == SSREG_SRC_LOCAL &&
     hit(addr, `SSREG_SLOTFMT_ADDR)) |=> $stable(fmt_stage_reg))
    else $error("subordinate took local format write");

  hold_act_a: assert property (@(posedge mclk)
    disable iff (rst) !commit |=> $stable(up_act_reg) &&
    $stable(resp_act_reg) && $stable(fmt_act_reg))
    else $error("active value moved without commit");

  commit_copy_a: assert property (@(posedge mclk)
    disable iff (rst) commit |=> fmt_act_reg == $past(fmt_stage_reg) &&
    up_act_reg == $past(up_stage_reg) &&
    resp_act_reg == $past(resp_stage_reg))
    else $error("commit did not copy staged values");

  // reads show the pending value, not the one in force
  rd_stage_a: assert property (@(posedge mclk)
    disable iff (rst) (rd_en && hit(addr, `SSREG_UPSTREAM_SLOT_FIELD_ADDR)) |=>
    rd_valid && rdata == $past(up_stage_reg))
    else $error("read did not show pending count");

  disc_load_a: assert property (@(posedge mclk)
    disable iff (rst) (discovery && is_main) |=>
    disc_reg == $past(resp_stage_reg))
    else $error("discovery value not loaded");

  // the word raised next cycle is the one just written
  sequence bc_start_s;
    ##1 (bc_valid && bc_data == $past(wdata));
  endsequence
  bc_send_a: assert property (@(posedge mclk)
    disable iff (rst) fmt_bcast |-> bc_start_s)
    else $error("format broadcast not raised");

  // an untaken word must not vanish or change under the sink
  bc_hold_a: assert property (@(posedge mclk)
    disable iff (rst) (bc_valid && !bc_ready && !fmt_bcast) |=>
    bc_valid && $stable(bc_data))
    else $error("broadcast dropped before taken");

  bc_done_a: assert property (@(posedge mclk)
    disable iff (rst) (bc_valid && bc_ready && !fmt_bcast) |=> !bc_valid)
    else $error("broadcast still raised after taken");

  hdr_scale_a: assert property (@(posedge mclk)
    disable iff (rst) up_hdr_bit == 10'(resp_cyc_act * `SSREG_RESP_SCALE))
    else $error("header offset not four times value");

  sf_period_a: assert property (@(posedge mclk)
    disable iff (rst) sf_start |=> !sf_start [*8])
    else $error("superframe start repeated early");

  // start exactly when the independent gap count reaches a superframe
  sf_gap_a: assert property (@(posedge mclk)
    disable iff (rst) sf_start == (sf_gap_reg == `SSREG_SUPERFRAME_BITS))
    else $error("superframe length wrong");

  up_field_a: assert property (@(posedge mclk)
    disable iff (rst) wr_up |=> up_stage_reg[7:6] == 2'b00 &&
    up_stage_reg[5:0] == $past(wdata[5:0]))
    else $error("upstream count field wrong");

  ecc_a: assert property (@(posedge mclk)
    disable iff (rst) (up_enc == SSREG_ENC_ECC) |-> (up_ecc_bits == 3'h6 ||
    up_ecc_bits == 3'h7))
    else $error("check bit count wrong");
endmodule : ssreg_bank
`default_nettype wire

// >>> test/ssreg_bc_sink.sv
// broadcast sink standing for the discovered subordinate nodes
`timescale 1ns/10ps
`default_nettype none
module ssreg_bc_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic bc_valid,
  input wire logic [7:0] bc_data,
  output logic bc_ready,
  output logic [7:0] got_data,
  output logic [7:0] got_count
);
  logic [1:0] wait_reg; // stall cycles so far
  // a slow node holds ready off for three cycles to test the stall
  assign bc_ready = bc_valid && (!slow || wait_reg == 2'h3);
  // take each byte once, every node adopts the same format
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wait_reg <= 2'h0;
      got_data <= 8'h00;
      got_count <= 8'h00;
    end
    else if (bc_ready)
    begin
      wait_reg <= 2'h0;
      got_data <= bc_data;
      got_count <= got_count + 8'h01;
    end
    else if (bc_valid)
    begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule : ssreg_bc_sink
`default_nettype wire

// >>> test/test_superframe_slot_structure_regs.sv
// self-checking bench for the slot structure register bank
`timescale 1ns/10ps
`default_nettype none
module test_superframe_slot_structure_regs
  import ssreg_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, is_main = 1'b0, slow = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0, commit = 1'b0, discovery = 1'b0;
  ssreg_src_t wr_src = SSREG_SRC_BUS;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata, bc_data, disc_timing, resp_cyc_act, slot_fmt_act;
  logic [7:0] got_data, got_count;
  logic rd_valid, bc_valid, bc_ready, sf_start;
  logic [5:0] up_slots_act;
  logic [9:0] up_hdr_bit;
  ssreg_enc_t up_enc;
  logic [2:0] up_ecc_bits;
  int bad_count = 0, compares = 0, n;
  always #4 mclk = ~mclk;
  ssreg_bank #(.ADDR_W(8)) DUT (.mclk(mclk), .rst(rst), .is_main(is_main),
    .wr_en(wr_en), .rd_en(rd_en), .wr_src(wr_src), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .commit(commit),
    .discovery(discovery), .bc_ready(bc_ready), .bc_valid(bc_valid),
    .bc_data(bc_data), .disc_timing(disc_timing),
    .up_slots_act(up_slots_act), .resp_cyc_act(resp_cyc_act),
    .slot_fmt_act(slot_fmt_act), .up_hdr_bit(up_hdr_bit), .up_enc(up_enc),
    .up_ecc_bits(up_ecc_bits), .sf_start(sf_start));
  ssreg_bc_sink sink (.mclk(mclk), .rst(rst), .slow(slow),
    .bc_valid(bc_valid), .bc_data(bc_data), .bc_ready(bc_ready),
    .got_data(got_data), .got_count(got_count));
  task automatic check(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one-cycle write strobe, taken at the edge that releases it
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input ssreg_src_t s);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    wr_src <= s;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // read strobe; rd_valid stands only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check("rd_valid", rd_valid, 1'b1);
    check("rdata", rdata, e);
  endtask : rd
  // commit or discovery pulse, then let the active copy settle
  task automatic strobe(input bit is_commit);
    @(posedge mclk);
    if (is_commit)
      commit <= 1'b1;
    else
      discovery <= 1'b1;
    @(posedge mclk);
    commit <= 1'b0;
    discovery <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : strobe
  // expected {encoding, protection bits} for {format bit, width code}
  function automatic logic [5:0] fmt_exp(input logic [3:0] f);
    if (!f[3] || f[2:0] == 3'h0 || f[2:0] == 3'h5)
      return {3'h1, 3'h0};
    if (f[2:0] < 3'h4)
      return {3'h2, 3'h0};
    return (f[2:0] == 3'h4) ? {3'h4, 3'h6} : {3'h4, 3'h7};
  endfunction : fmt_exp
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h40);
    rd(8'h11, 8'h00);
    check("disc", disc_timing, 8'h40);
    wr(8'h0f, 8'h12, SSREG_SRC_LOCAL);
    rd(8'h0f, 8'h40);
    wr(8'h0f, 8'h25, SSREG_SRC_BUS);
    wr(8'h0e, 8'h20, SSREG_SRC_BUS);
    rd(8'h0f, 8'h25);
    check("resp_act", resp_cyc_act, 8'h40);
    check("slots_act", up_slots_act, 6'h00);
    strobe(1'b1);
    check("resp_act", resp_cyc_act, 8'h25);
    check("slots_act", up_slots_act, 6'h20);
    check("hdr_bit", up_hdr_bit, 10'h094);
    // a subordinate ignores discovery, the main node loads it
    strobe(1'b0);
    check("disc", disc_timing, 8'h40);
    @(posedge mclk);
    is_main <= 1'b1;
    strobe(1'b0);
    check("disc", disc_timing, 8'h25);
    // main local format write goes out, sink stalls it
    slow <= 1'b1;
    wr(8'h10, 8'h5a, SSREG_SRC_LOCAL);
    repeat (2) @(posedge mclk);
    #1;
    check("bc_valid", bc_valid, 1'b1);
    check("bc_data", bc_data, 8'h5a);
    repeat (6) @(posedge mclk);
    #1;
    check("got_data", got_data, 8'h5a);
    check("got_count", got_count, 8'h01);
    check("bc_done", bc_valid, 1'b0);
    is_main <= 1'b0;
    wr(8'h10, 8'h33, SSREG_SRC_LOCAL);
    rd(8'h10, 8'h5a);
    check("got_count", got_count, 8'h01);
    // every width code with and without the alternate format
    for (int f = 0; f < 16; f++)
    begin
      if (f[2:0] == 3'h7)
        continue;
      wr(8'h10, {f[3:0], 4'h0}, SSREG_SRC_BUS);
      strobe(1'b1);
      check("fmt_act", slot_fmt_act, {f[3:0], 4'h0});
      check("enc", {up_enc, up_ecc_bits}, fmt_exp(f[3:0]));
    end
    // superframe period: align on one start, count to the next
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge mclk);
        #1;
        n++;
      end
      while (sf_start !== 1'b1 && n < 2000);
    end
    check("sf_period", n[15:0], 16'h0400);
    final_report();
  end
endmodule : test_superframe_slot_structure_regs
`default_nettype wire
